// >>> hw/pmx_top.sv
// Purpose: Per-pad choice between general-purpose port and peripheral or bus function.
// Assumes: All pad inputs are asynchronous and pass two flops; every output is registered.
// Notes: Pad drive lags its control inputs by one clock; pad reads lag the pad by three.
//
// What this block does
// R01 - Analog disabled: ordinary read of open-drain data returns pin level.
// R02 - Analog disabled: written open-drain data drives the pin directly.
// R03 - Software sets analog enable and data to 1 for analog use.
// R04 - Timer pads are ports unless both timer outputs are enabled.
// R05 - Serial clock pad is a port only while clock output is off.
// R06 - Serial data out pad carries data when enabled, else port.
// R07 - Serial input and interrupt pads stay ports; peripheral samples them.
// R08 - Software disables other outputs on pads used as peripheral inputs.
// R09 - Clock pad outputs machine clock when enabled, else port.
// R10 - Ready pad feeds wait control only when ready function enabled.
// R11 - Hold enabled: request input and acknowledge output pads, else ports.
// R12 - Upper write strobe only in 16-bit mode with output enabled.
// R13 - Lower write strobe on pad when enabled, else port.
// R14 - Upper data pads are bus bits in 16-bit mode, else ports.
// R15 - Lower data pads always serve as bus bits 0 to 7.
// R16 - Read strobe pad is dedicated to the bus read strobe.
// R17 - Interrupt input two clamped low in stop; only zero and one wake. Input three is left unclamped in stop.
// R18 - Mode select inputs are tied statically by the board.
// R19 - Standby input held high while power is applied.
// R20 - Standby input not driven low while reset is held low.
`default_nettype none
module pmx_top
  import pmx_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire pmx_fn_en_t FN_EN_I,
  input wire pmx_fn_drv_t FN_DRV_I,
  input wire logic STOP_I,
  input wire logic [PMX_GEN_W-1:0] GEN_PORT_DATA_I,
  input wire logic [PMX_GEN_W-1:0] GEN_PORT_DIR_I,
  input wire logic [PMX_GEN_W-1:0] GEN_PAD_I,
  output logic [PMX_GEN_W-1:0] GEN_PAD_O,
  output logic [PMX_GEN_W-1:0] GEN_PAD_OE_O,
  output logic [PMX_GEN_W-1:0] GEN_PORT_PIN_O,
  input wire logic [PMX_OD_W-1:0] ANALOG_EN_I,
  input wire logic [PMX_OD_W-1:0] OD_DATA_I,
  input wire logic OD_RMW_READ_I,
  input wire logic [PMX_OD_W-1:0] OD_PAD_I,
  output logic [PMX_OD_W-1:0] OD_PAD_O,
  output logic [PMX_OD_W-1:0] OD_PAD_OE_O,
  output logic [PMX_OD_W-1:0] OD_READ_O,
  output logic [PMX_OD_W-1:0] ANALOG_CONNECT_O,
  input wire logic [PMX_DAT_W-1:0] BUS_DATA_I,
  input wire logic BUS_DATA_OE_I,
  input wire logic [7:0] UPPER_PORT_DATA_I,
  input wire logic [7:0] UPPER_PORT_DIR_I,
  input wire logic [PMX_DAT_W-1:0] DATA_PAD_I,
  output logic [PMX_DAT_W-1:0] DATA_PAD_O,
  output logic [PMX_DAT_W-1:0] DATA_PAD_OE_O,
  output logic [PMX_DAT_W-1:0] BUS_DATA_O,
  output logic RD_N_O,
  output logic [PMX_IRQ_W-1:0] IRQ_O,
  output logic CAPTURE3_O,
  output logic CONV_TRIG_O,
  output logic SER_CLK_O,
  output logic SER_DIN_O,
  output logic BUS_READY_O,
  output logic HOLD_REQ_O
);

  pmx_state_t st_reg;
  pmx_state_t st_next;

  // Next state: synchronisers, pad drive selection and peripheral input routing
  always_comb begin
    logic [PMX_GEN_W-1:0] fn_sel;
    logic [PMX_GEN_W-1:0] fn_out;
    logic [PMX_GEN_W-1:0] fn_oe;
    fn_sel = '0;
    fn_out = '0;
    fn_oe = '0;
    st_next = st_reg;
    // First flops feed only the second flops
    st_next.gen_s1 = GEN_PAD_I;
    st_next.gen_s2 = st_reg.gen_s1;
    st_next.od_s1 = OD_PAD_I;
    st_next.od_s2 = st_reg.od_s1;
    st_next.dat_s1 = DATA_PAD_I;
    st_next.dat_s2 = st_reg.dat_s1;
    // Timer pads switch as a pair; a half-enabled pair stays on the port
    if (FN_EN_I.tmr0_out_en && FN_EN_I.tmr1_out_en) begin // [R04]
      fn_sel[PMX_PAD_TMR1:PMX_PAD_TMR0] = 2'h3;
      fn_out[PMX_PAD_TMR1:PMX_PAD_TMR0] = FN_DRV_I.timer_out;
      fn_oe[PMX_PAD_TMR1:PMX_PAD_TMR0] = 2'h3;
    end
    fn_sel[PMX_PAD_SCLK] = FN_EN_I.ser_clk_out_en; // [R05]
    fn_out[PMX_PAD_SCLK] = FN_DRV_I.ser_clk;
    fn_oe[PMX_PAD_SCLK] = 1'h1;
    fn_sel[PMX_PAD_SDOUT] = FN_EN_I.ser_dout_en; // [R06]
    fn_out[PMX_PAD_SDOUT] = FN_DRV_I.ser_dout;
    fn_oe[PMX_PAD_SDOUT] = 1'h1;
    fn_sel[PMX_PAD_CLK] = FN_EN_I.clk_out_en; // [R09]
    fn_out[PMX_PAD_CLK] = FN_DRV_I.mach_clk;
    fn_oe[PMX_PAD_CLK] = 1'h1;
    // Ready is input only: the selected pad is simply released
    fn_sel[PMX_PAD_RDY] = FN_EN_I.ready_en; // [R10]
    fn_sel[PMX_PAD_HACK] = FN_EN_I.hold_en; // [R11]
    fn_out[PMX_PAD_HACK] = FN_DRV_I.hold_ack;
    fn_oe[PMX_PAD_HACK] = 1'h1;
    fn_sel[PMX_PAD_HREQ] = FN_EN_I.hold_en; // [R11]
    fn_sel[PMX_PAD_WRU] = FN_EN_I.bus16 && FN_EN_I.wru_en; // [R12]
    fn_out[PMX_PAD_WRU] = FN_DRV_I.wr_upper_n;
    fn_oe[PMX_PAD_WRU] = 1'h1;
    fn_sel[PMX_PAD_WR_LOW] = FN_EN_I.wr_low_en; // [R13]
    fn_out[PMX_PAD_WR_LOW] = FN_DRV_I.wr_lower_n;
    fn_oe[PMX_PAD_WR_LOW] = 1'h1;
    // Serial input and interrupt pads are never claimed, so the port keeps them
    for (int i = 0; i < PMX_GEN_W; i++) begin // [R07]
      st_next.gen_out[i] = fn_sel[i] ? fn_out[i] : GEN_PORT_DATA_I[i];
      st_next.gen_oe[i] = fn_sel[i] ? fn_oe[i] : GEN_PORT_DIR_I[i];
    end
    st_next.gen_pin = st_reg.gen_s2;
    // Open-drain pads only ever pull low; a 1 releases the pad
    for (int i = 0; i < PMX_OD_W; i++) begin
      st_next.od_out[i] = 1'h0;
      st_next.od_oe[i] = !OD_DATA_I[i]; // [R02]
      st_next.od_read[i] = (ANALOG_EN_I[i] || OD_RMW_READ_I) ? OD_DATA_I[i] : st_reg.od_s2[i]; // [R01]
      // Analog path is only useful with the driver released
      st_next.an_conn[i] = ANALOG_EN_I[i] && OD_DATA_I[i];
    end
    // Lower data byte is bus only; upper byte follows the bus width
    st_next.dat_out[PMX_DAT_UP_LSB-1:0] = BUS_DATA_I[PMX_DAT_UP_LSB-1:0]; // [R15]
    st_next.dat_oe[PMX_DAT_UP_LSB-1:0] = {PMX_DAT_UP_LSB{BUS_DATA_OE_I}};
    if (FN_EN_I.bus16) begin // [R14]
      st_next.dat_out[PMX_DAT_W-1:PMX_DAT_UP_LSB] = BUS_DATA_I[PMX_DAT_W-1:PMX_DAT_UP_LSB];
      st_next.dat_oe[PMX_DAT_W-1:PMX_DAT_UP_LSB] = {(PMX_DAT_W-PMX_DAT_UP_LSB){BUS_DATA_OE_I}};
    end else begin
      st_next.dat_out[PMX_DAT_W-1:PMX_DAT_UP_LSB] = UPPER_PORT_DATA_I;
      st_next.dat_oe[PMX_DAT_W-1:PMX_DAT_UP_LSB] = UPPER_PORT_DIR_I;
    end
    st_next.bus_rd = st_reg.dat_s2;
    st_next.rd_n = FN_DRV_I.rd_n; // [R16]
    // Peripheral inputs sample the synchronised pads regardless of port use
    st_next.irq[0] = st_reg.gen_s2[PMX_PAD_IRQ0];
    st_next.irq[1] = st_reg.gen_s2[PMX_PAD_IRQ1];
    st_next.irq[PMX_IRQ_TWO] = st_reg.gen_s2[PMX_PAD_IRQ2] && !STOP_I; // [R17]
    st_next.irq[PMX_IRQ_THREE] = st_reg.gen_s2[PMX_PAD_IRQ3];
    st_next.cap3 = st_reg.gen_s2[PMX_PAD_IRQ3];
    st_next.trig = st_reg.gen_s2[PMX_PAD_IRQ2];
    st_next.ser_clk_in = st_reg.gen_s2[PMX_PAD_SCLK];
    st_next.ser_din = st_reg.gen_s2[PMX_PAD_SDIN];
    // Without the ready function the bus never waits
    st_next.ready = FN_EN_I.ready_en ? st_reg.gen_s2[PMX_PAD_RDY] : 1'h1; // [R10]
    st_next.hold_req = FN_EN_I.hold_en && st_reg.gen_s2[PMX_PAD_HREQ]; // [R11]
  end

  // Single state register
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      st_reg <= PMX_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign GEN_PAD_O = st_reg.gen_out;
  assign GEN_PAD_OE_O = st_reg.gen_oe;
  assign GEN_PORT_PIN_O = st_reg.gen_pin;
  assign OD_PAD_O = st_reg.od_out;
  assign OD_PAD_OE_O = st_reg.od_oe;
  assign OD_READ_O = st_reg.od_read;
  assign ANALOG_CONNECT_O = st_reg.an_conn;
  assign DATA_PAD_O = st_reg.dat_out;
  assign DATA_PAD_OE_O = st_reg.dat_oe;
  assign BUS_DATA_O = st_reg.bus_rd;
  assign RD_N_O = st_reg.rd_n;
  assign IRQ_O = st_reg.irq;
  assign CAPTURE3_O = st_reg.cap3;
  assign CONV_TRIG_O = st_reg.trig;
  assign SER_CLK_O = st_reg.ser_clk_in;
  assign SER_DIN_O = st_reg.ser_din;
  assign BUS_READY_O = st_reg.ready;
  assign HOLD_REQ_O = st_reg.hold_req;

  // Checks on pad selection and peripheral input routing
  od_read_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R01]
    (!ANALOG_EN_I[0] && !OD_RMW_READ_I) |=> OD_READ_O[0] == $past(st_reg.od_s2[0]))
    else $error("open-drain read did not return pin level");
  od_drive_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R02]
    1'h1 |=> (OD_PAD_OE_O == ~$past(OD_DATA_I)) && (OD_PAD_O == '0))
    else $error("open-drain pad not following written data");
  timer_pair_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R04]
    (FN_EN_I.tmr0_out_en && FN_EN_I.tmr1_out_en) |=>
      (GEN_PAD_O[1:0] == $past(FN_DRV_I.timer_out)) && (GEN_PAD_OE_O[1:0] == 2'h3))
    else $error("timer pads not carrying timer outputs");
  sclk_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R05]
    !FN_EN_I.ser_clk_out_en |=> GEN_PAD_OE_O[PMX_PAD_SCLK] == $past(GEN_PORT_DIR_I[PMX_PAD_SCLK]))
    else $error("serial clock pad not released to port");
  sdout_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R06]
    FN_EN_I.ser_dout_en |=> GEN_PAD_OE_O[PMX_PAD_SDOUT] && GEN_PAD_O[PMX_PAD_SDOUT] == $past(FN_DRV_I.ser_dout))
    else $error("serial data pad not driven");
  port_keep_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R07]
    1'h1 |=> GEN_PAD_O[PMX_PAD_SDIN] == $past(GEN_PORT_DATA_I[PMX_PAD_SDIN]))
    else $error("serial input pad lost its port");
  clk_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R09]
    FN_EN_I.clk_out_en |=> GEN_PAD_O[PMX_PAD_CLK] == $past(FN_DRV_I.mach_clk))
    else $error("clock pad not carrying machine clock");
  ready_off_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R10]
    !FN_EN_I.ready_en |=> BUS_READY_O)
    else $error("bus waited with ready disabled");
  hold_off_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R11]
    !FN_EN_I.hold_en |=> !HOLD_REQ_O)
    else $error("hold request passed while disabled");
  wru_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R12]
    !FN_EN_I.bus16 |=> GEN_PAD_O[PMX_PAD_WRU] == $past(GEN_PORT_DATA_I[PMX_PAD_WRU]))
    else $error("upper write strobe in 8-bit mode");
  wr_low_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R13]
    FN_EN_I.wr_low_en |=> GEN_PAD_O[PMX_PAD_WR_LOW] == $past(FN_DRV_I.wr_lower_n))
    else $error("lower write strobe missing");
  data_up_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R14]
    !FN_EN_I.bus16 |=> DATA_PAD_O[15:8] == $past(UPPER_PORT_DATA_I))
    else $error("upper data pads not on port in 8-bit mode");
  data_low_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R15]
    1'h1 |=> DATA_PAD_O[7:0] == $past(BUS_DATA_I[7:0]))
    else $error("lower data pads left the bus");
  rd_pad_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R16]
    1'h1 |=> RD_N_O == $past(FN_DRV_I.rd_n))
    else $error("read strobe not passed");
  stop_clamp_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I) // [R17]
    STOP_I |=> !IRQ_O[PMX_IRQ_TWO])
    else $error("interrupt two not clamped in stop");
endmodule : pmx_top
`default_nettype wire

// >>> inc/pmx_pkg.sv
// Purpose: Shared constants and types for the pin function multiplexer.
// Assumes: One core clock, synchronous active-low reset.
// Notes: Pad indices name the position of each shared pad in the general pad vector.
`default_nettype none
package pmx_pkg;
  // Widths of the pad groups
  localparam int PMX_GEN_W = 16;
  localparam int PMX_OD_W = 6;
  localparam int PMX_DAT_W = 16;
  localparam int PMX_IRQ_W = 4;
  // Positions inside the general pad vector
  localparam int PMX_PAD_TMR0 = 0;
  localparam int PMX_PAD_TMR1 = 1;
  localparam int PMX_PAD_GP = 2;
  localparam int PMX_PAD_SCLK = 3;
  localparam int PMX_PAD_SDIN = 4;
  localparam int PMX_PAD_SDOUT = 5;
  localparam int PMX_PAD_IRQ0 = 6;
  localparam int PMX_PAD_IRQ1 = 7;
  localparam int PMX_PAD_IRQ2 = 8;
  localparam int PMX_PAD_CLK = 9;
  localparam int PMX_PAD_RDY = 10;
  localparam int PMX_PAD_HACK = 11;
  localparam int PMX_PAD_HREQ = 12;
  localparam int PMX_PAD_WRU = 13;
  localparam int PMX_PAD_WR_LOW = 14;
  localparam int PMX_PAD_IRQ3 = 15;
  // Data bus halves
  localparam int PMX_DAT_UP_LSB = 8;
  // Positions inside the interrupt output vector
  localparam int PMX_IRQ_TWO = 2;
  localparam int PMX_IRQ_THREE = 3;

  // Function enables written by software
  typedef struct packed {
    logic tmr0_out_en;
    logic tmr1_out_en;
    logic ser_clk_out_en;
    logic ser_dout_en;
    logic clk_out_en;
    logic ready_en;
    logic hold_en;
    logic bus16;
    logic wru_en;
    logic wr_low_en;
  } pmx_fn_en_t;

  // Signals that peripherals and the bus unit want on their pads
  typedef struct packed {
    logic [1:0] timer_out;
    logic ser_clk;
    logic ser_dout;
    logic mach_clk;
    logic hold_ack;
    logic wr_upper_n;
    logic wr_lower_n;
    logic rd_n;
  } pmx_fn_drv_t;

  // Whole state of the multiplexer
  typedef struct packed {
    logic [PMX_GEN_W-1:0] gen_s1;
    logic [PMX_GEN_W-1:0] gen_s2;
    logic [PMX_OD_W-1:0] od_s1;
    logic [PMX_OD_W-1:0] od_s2;
    logic [PMX_DAT_W-1:0] dat_s1;
    logic [PMX_DAT_W-1:0] dat_s2;
    logic [PMX_GEN_W-1:0] gen_out;
    logic [PMX_GEN_W-1:0] gen_oe;
    logic [PMX_GEN_W-1:0] gen_pin;
    logic [PMX_OD_W-1:0] od_out;
    logic [PMX_OD_W-1:0] od_oe;
    logic [PMX_OD_W-1:0] od_read;
    logic [PMX_OD_W-1:0] an_conn;
    logic [PMX_DAT_W-1:0] dat_out;
    logic [PMX_DAT_W-1:0] dat_oe;
    logic [PMX_DAT_W-1:0] bus_rd;
    logic [PMX_IRQ_W-1:0] irq;
    logic rd_n;
    logic cap3;
    logic trig;
    logic ser_clk_in;
    logic ser_din;
    logic ready;
    logic hold_req;
  } pmx_state_t;

  localparam pmx_state_t PMX_STATE_RST = '0;
endpackage : pmx_pkg
`default_nettype wire

// >>> sim/pmx_board_model.sv
// Purpose: Board and external bus devices facing the multiplexer pads.
// Assumes: The board drives a general or data pad only where the block has released it; it may sink open-drain lines at any time.
// Notes: Open-drain lines carry a pull-up; mode and standby pins are not modelled.
`default_nettype none
module pmx_board_model
  import pmx_pkg::*;
(
  input wire logic [PMX_GEN_W-1:0] gen_out_i,
  input wire logic [PMX_GEN_W-1:0] gen_oe_i,
  input wire logic [PMX_GEN_W-1:0] gen_ext_i,
  output logic [PMX_GEN_W-1:0] gen_pad_o,
  input wire logic [PMX_OD_W-1:0] od_oe_i,
  input wire logic [PMX_OD_W-1:0] od_low_i,
  output logic [PMX_OD_W-1:0] od_pad_o,
  input wire logic [PMX_DAT_W-1:0] dat_out_i,
  input wire logic [PMX_DAT_W-1:0] dat_oe_i,
  input wire logic [PMX_DAT_W-1:0] dat_ext_i,
  output logic [PMX_DAT_W-1:0] dat_pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mode straps stay wired to fixed levels and the standby line is held high through
  // power-up and reset; the block has no such inputs, so the board never moves them
  // Board drives only released pads, so it never fights a peripheral output
  assign gen_pad_o = (gen_oe_i & gen_out_i) | (~gen_oe_i & gen_ext_i);
  // Pull-up wins unless the block or the board sinks the line
  assign od_pad_o = ~(od_oe_i | od_low_i);
  // Bus device answers on data lines the block does not drive
  assign dat_pad_o = (dat_oe_i & dat_out_i) | (~dat_oe_i & dat_ext_i);
endmodule : pmx_board_model
`default_nettype wire

// >>> sim/pmx_top_tb.sv
// Purpose: Random and corner stimulus for the pin function multiplexer.
// Assumes: Drive path settles one edge after inputs, read path three edges later.
// Notes: Expected pad levels come from the bench's own functions, not the pads.
`default_nettype none
module pmx_top_tb
  import pmx_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, stop, rmw, boe, rdn, cap, trig, sclk, sdin, rdy, hreq;
  pmx_fn_en_t en;
  pmx_fn_drv_t drv;
  logic [15:0] gdat, gdir, gext, gpo, goe, gpin, gpad, bdat, dext, dpo, doe, bout, dpad, glv, dlv;
  logic [31:0] eg, ed;
  logic [7:0] udat, udir;
  logic [5:0] aen, odd, odl, odpad, odpo, odoe, odrd, anc, sel;
  logic [3:0] irq;
  logic [9:0] corner [5] = '{10'h000, 10'h200, 10'h3FF, 10'h002, 10'h3FB};
  int miscompares = 0;
  int check_count = 0;

  pmx_top pmx_top_i (.MCLK_I(clk), .NRST_I(rst_n), .FN_EN_I(en), .FN_DRV_I(drv), .STOP_I(stop),
    .GEN_PORT_DATA_I(gdat), .GEN_PORT_DIR_I(gdir), .GEN_PAD_I(gpad), .GEN_PAD_O(gpo), .GEN_PAD_OE_O(goe),
    .GEN_PORT_PIN_O(gpin), .ANALOG_EN_I(aen), .OD_DATA_I(odd), .OD_RMW_READ_I(rmw), .OD_PAD_I(odpad),
    .OD_PAD_O(odpo), .OD_PAD_OE_O(odoe), .OD_READ_O(odrd), .ANALOG_CONNECT_O(anc), .BUS_DATA_I(bdat),
    .BUS_DATA_OE_I(boe), .UPPER_PORT_DATA_I(udat), .UPPER_PORT_DIR_I(udir), .DATA_PAD_I(dpad),
    .DATA_PAD_O(dpo), .DATA_PAD_OE_O(doe), .BUS_DATA_O(bout), .RD_N_O(rdn), .IRQ_O(irq),
    .CAPTURE3_O(cap), .CONV_TRIG_O(trig), .SER_CLK_O(sclk), .SER_DIN_O(sdin), .BUS_READY_O(rdy),
    .HOLD_REQ_O(hreq));
  pmx_board_model pmx_board_model_i (.gen_out_i(gpo), .gen_oe_i(goe), .gen_ext_i(gext), .gen_pad_o(gpad),
    .od_oe_i(odoe), .od_low_i(odl), .od_pad_o(odpad), .dat_out_i(dpo), .dat_oe_i(doe), .dat_ext_i(dext),
    .dat_pad_o(dpad));

  // Free-running core clock, 100 ns period
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Expected general pad drive as {enable, value masked by enable}
  function automatic logic [31:0] exp_gen(input pmx_fn_en_t e, input pmx_fn_drv_t d, input logic [15:0] dt,
    input logic [15:0] dr);
    logic [15:0] o, v;
    o = dt;
    v = dr;
    if (e.tmr0_out_en && e.tmr1_out_en) begin
      o[1:0] = d.timer_out;
      v[1:0] = 2'h3;
    end
    if (e.ser_clk_out_en) begin o[3] = d.ser_clk; v[3] = 1'h1; end
    if (e.ser_dout_en) begin o[5] = d.ser_dout; v[5] = 1'h1; end
    if (e.clk_out_en) begin o[9] = d.mach_clk; v[9] = 1'h1; end
    if (e.ready_en) v[10] = 1'h0;
    if (e.hold_en) begin o[11] = d.hold_ack; v[11] = 1'h1; v[12] = 1'h0; end
    if (e.bus16 && e.wru_en) begin o[13] = d.wr_upper_n; v[13] = 1'h1; end
    if (e.wr_low_en) begin o[14] = d.wr_lower_n; v[14] = 1'h1; end
    return {v, o & v};
  endfunction : exp_gen

  // Expected data pad drive; upper byte is a port unless the bus is 16 bits wide
  function automatic logic [31:0] exp_dat(input logic b16, input logic [15:0] bd, input logic oe,
    input logic [7:0] ud, input logic [7:0] ur);
    logic [15:0] o, v;
    o = b16 ? bd : {ud, bd[7:0]};
    v = b16 ? {16{oe}} : {ur, {8{oe}}};
    return {v, o & v};
  endfunction : exp_dat

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Cuts a hang short well beyond the expected 816 cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    {rst_n, stop, rmw, boe, gdat, gdir, gext, bdat, dext, udat, udir, aen, odd, odl} = '0;
    en = '0;
    drv = '0;
    void'($urandom(75));
    repeat (16) @(posedge clk);
    #1;
    chk({goe, doe, odoe, rdn, rdy}, '0);
    rst_n = 1'h1;
    for (int i = 0; i < 200; i++) begin
      en = (i < 5) ? pmx_fn_en_t'(corner[i]) : pmx_fn_en_t'(10'($urandom));
      drv = pmx_fn_drv_t'(10'($urandom));
      {gdat, gdir} = $urandom;
      {gext, bdat} = $urandom;
      {dext, udat, udir} = $urandom;
      {stop, rmw, boe, aen, odd, odl} = 21'($urandom);
      odd = odd | aen; // Analog pins get data 1 so the driver lets go
      eg = exp_gen(en, drv, gdat, gdir);
      ed = exp_dat(en.bus16, bdat, boe, udat, udir);
      @(posedge clk);
      #1;
      chk({goe, gpo & goe}, eg);
      chk({doe, dpo & doe}, ed);
      chk({odpo, odoe, anc}, {6'h00, ~odd, aen & odd});
      chk(rdn, drv.rd_n);
      glv = eg[31:16] & eg[15:0] | ~eg[31:16] & gext;
      dlv = ed[31:16] & ed[15:0] | ~ed[31:16] & dext;
      sel = aen | {6{rmw}};
      repeat (3) @(posedge clk);
      #1;
      chk(gpin, glv);
      chk(irq, {glv[15], glv[8] & ~stop, glv[7], glv[6]});
      chk({cap, trig, sclk, sdin}, {glv[15], glv[8], glv[3], glv[4]});
      chk({rdy, hreq}, {en.ready_en ? glv[10] : 1'h1, en.hold_en & glv[12]});
      chk(odrd, (sel & odd) | (~sel & odd & ~odl));
      chk(bout, dlv);
    end
    close_out();
  end
endmodule : pmx_top_tb
`default_nettype wire
